/* File: cpg_pkg.sv */
// shared constants for the power-on reset gate
// assumes one 250 MHz free-running clock feeds every user
package cpg_pkg;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int CPG_CLK_PERIOD_PS = 4000;
  localparam int CPG_TPOR_NS_X10   = 95;   // 9.5 us, in tenths of a us
  // least time: round up to whole cycles
  localparam int CPG_TPOR_CYCLES   =
    (CPG_TPOR_NS_X10 * 100000 + CPG_CLK_PERIOD_PS - 1) / CPG_CLK_PERIOD_PS;
  localparam int CPG_CNT_W         = 12;

  // ****************************************************
  // supply monitor bit positions
  // ****************************************************
  localparam int CPG_MON_W      = 7;
  localparam int CPG_AN_DETECT  = 0;  // analog_supply above 0.5 V
  localparam int CPG_AN_ON      = 1;  // analog_supply above 1.1 V rising
  localparam int CPG_AN_OFF     = 2;  // analog_supply above 1.1 V falling
  localparam int CPG_CORE_ON    = 3;  // core_supply above 0.9 V rising
  localparam int CPG_CORE_OFF   = 4;  // core_supply above 0.65 V falling
  localparam int CPG_PLL_ON     = 5;  // pll_supply above 1.1 V rising
  localparam int CPG_PLL_OFF    = 6;  // pll_supply above 1.1 V falling
  localparam logic [6:0] CPG_MON_RESET = 7'h00;

  // ****************************************************
  // control port widths and modes
  // ****************************************************
  localparam int CPG_ADDR_W = 16;
  localparam int CPG_DATA_W = 16;

  typedef enum logic [1:0] {
    CPG_MODE_I2C  = 2'h0,
    CPG_MODE_SPI3 = 2'h1,
    CPG_MODE_SPI4 = 2'h2
  } cpg_mode_t;

  // gray along undefined -> hold -> count -> run
  typedef enum logic [1:0] {
    CPG_ST_UNDEF = 2'h0,
    CPG_ST_HOLD  = 2'h1,
    CPG_ST_COUNT = 2'h3,
    CPG_ST_RUN   = 2'h2
  } cpg_state_t;

endpackage

/* File: cpg_sync3.sv */
// three-stage synchroniser for asynchronous comparator levels
// assumes inputs are quasi-static analog monitor results
`timescale 1ns/100ps
`default_nettype none
module cpg_sync3 #(
  parameter int          W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] q;
  } cpg_sync_t;

  cpg_sync_t r_reg;
  cpg_sync_t r_next;

  // ****************************************************
  // a change counts only once stages two and three agree
  // ****************************************************
  always_comb begin
    r_next     = r_reg;
    r_next.ff1 = i_async;
    r_next.ff2 = r_reg.ff1;
    r_next.ff3 = r_reg.ff2;
    r_next.q   = (~(r_reg.ff2 ^ r_reg.ff3) & r_reg.ff3) |
                 ((r_reg.ff2 ^ r_reg.ff3) & r_reg.q);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r_reg <= '{ff1: RESET_VAL, ff2: RESET_VAL, ff3: RESET_VAL,
                 q: RESET_VAL};
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_sync = r_reg.q;

endmodule
`default_nettype wire

/* File: cpg_reset_gate.sv */
// power-on reset gate: main reset, pll reset and control write gate
// assumes comparator outputs from supply monitors, one system clock
`timescale 1ns/100ps
`default_nettype none
// What this block does
// [R1] main reset low while analog or core supply is below power-on level
// [R2] above the detection level reset is driven low and chip held
// [R3] control interface writes are discarded while main reset is low
// [R4] after release registers are at default and writes pass through
// [R5] main reset stays low for at least the minimum reset period
// [R6] reset returns at once when analog or core falls below power-off level
// [R7] a sag above the power-off levels never causes a reset
// [R8] pll reset keeps plls disabled while pll supply is below start-up
// [R9] fully operational only once all three supplies are above release
// [R10] with no pll supply the rest runs; oscillator, plls, clock pin off
// [R11] i2c, three- and four-wire spi modes; all registers read back
// [R12] reset period counted on the free-running clock, release synchronous
// [R13] pll reset is independent and never holds the main reset
module cpg_reset_gate
  import cpg_pkg::*;
#(
  parameter logic [CPG_CNT_W-1:0] POR_CYCLES = CPG_CNT_W'(CPG_TPOR_CYCLES),
  parameter int                   ADDR_W     = CPG_ADDR_W,
  parameter int                   DATA_W     = CPG_DATA_W
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_b,
  input  wire logic [6:0]        i_supply_mon,
  input  wire logic [1:0]        i_ctrl_mode,
  input  wire logic              i_wr_valid,
  input  wire logic [ADDR_W-1:0] i_wr_addr,
  input  wire logic [DATA_W-1:0] i_wr_data,
  input  wire logic              i_rd_valid,
  input  wire logic [ADDR_W-1:0] i_rd_addr,
  output logic                   o_main_rst_b,
  output logic                   o_pll_rst_b,
  output logic                   o_pll_enable,
  output logic                   o_xtal_enable,
  output logic                   o_clock_output_pin_enable,
  output logic                   o_fully_operational,
  output logic [1:0]             o_ctrl_mode,
  output logic                   o_wr_valid,
  output logic [ADDR_W-1:0]      o_wr_addr,
  output logic [DATA_W-1:0]      o_wr_data,
  output logic                   o_wr_dropped,
  output logic                   o_rd_valid,
  output logic [ADDR_W-1:0]      o_rd_addr
);

  typedef struct packed {
    cpg_state_t            st;
    logic [CPG_CNT_W-1:0]  cnt;
    logic                  main_rst_b;
    logic                  pll_ok;
    cpg_mode_t             mode;
    logic                  wr_valid;
    logic                  wr_drop;
    logic [ADDR_W-1:0]     wr_addr;
    logic [DATA_W-1:0]     wr_data;
    logic                  rd_valid;
    logic [ADDR_W-1:0]     rd_addr;
  } cpg_gate_t;

  cpg_gate_t  r_reg;
  cpg_gate_t  r_next;
  logic [6:0] mon;
  logic [1:0] mode_pin;
  logic       s_det;
  logic       s_an_on;
  logic       s_an_off;
  logic       s_core_on;
  logic       s_core_off;
  logic       s_pll_on;
  logic       s_pll_off;

  // ****************************************************
  // comparator inputs cross in from the analog monitors
  // ****************************************************
  cpg_sync3 #(
    .W         (CPG_MON_W),
    .RESET_VAL (CPG_MON_RESET)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_async   (i_supply_mon),
    .o_sync    (mon)
  );

  // the mode strap is a pin as well, so it crosses the same way
  cpg_sync3 #(
    .W         (2),
    .RESET_VAL (CPG_MODE_I2C)
  ) u_mode_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_async   (i_ctrl_mode),
    .o_sync    (mode_pin)
  );

  assign s_det      = mon[CPG_AN_DETECT];
  assign s_an_on    = mon[CPG_AN_ON];
  assign s_an_off   = mon[CPG_AN_OFF];
  assign s_core_on  = mon[CPG_CORE_ON];
  assign s_core_off = mon[CPG_CORE_OFF];
  assign s_pll_on   = mon[CPG_PLL_ON];
  assign s_pll_off  = mon[CPG_PLL_OFF];

  // ****************************************************
  // sequencer and write gate
  // ****************************************************
  always_comb begin
    r_next          = r_reg;
    r_next.wr_valid = 1'b0;
    r_next.wr_drop  = 1'b0;
    r_next.rd_valid = 1'b0;
    case (r_reg.st)
      CPG_ST_UNDEF: begin
        r_next.cnt = '0;
        if (s_det) begin
          r_next.st = CPG_ST_HOLD; // R2
        end
      end
      CPG_ST_HOLD: begin
        r_next.cnt = '0;
        // mode strap is caught while the chip is held
        case (mode_pin)
          2'h1:    r_next.mode = CPG_MODE_SPI3; // R11
          2'h2:    r_next.mode = CPG_MODE_SPI4; // R11
          default: r_next.mode = CPG_MODE_I2C; // R11
        endcase
        if (s_an_on && s_core_on) begin
          r_next.st = CPG_ST_COUNT; // R1
        end
      end
      CPG_ST_COUNT: begin
        // zero rise time still waits the full count; a dip below an
        // on level before release restarts it
        if (!s_an_on || !s_core_on) begin
          r_next.st = CPG_ST_HOLD; // R1 R6
        end else if (r_reg.cnt == POR_CYCLES - 1'b1) begin
          r_next.st = CPG_ST_RUN; // R5 R12
        end else begin
          r_next.cnt = r_reg.cnt + 1'b1; // R12
        end
      end
      CPG_ST_RUN: begin
        // only the off levels matter here, so brown-outs ride through
        if (!s_an_off || !s_core_off) begin
          r_next.st = CPG_ST_HOLD; // R6 R7
        end
      end
      default: begin
        r_next.st = CPG_ST_UNDEF;
      end
    endcase
    if (!s_det) begin
      r_next.st = CPG_ST_UNDEF; // R2
    end
    r_next.main_rst_b = (r_next.st == CPG_ST_RUN); // R1 R12

    // pll reset has its own thresholds and never touches the sequencer
    if (!r_reg.pll_ok && s_pll_on) begin
      r_next.pll_ok = 1'b1; // R8 R13
    end else if (r_reg.pll_ok && !s_pll_off) begin
      r_next.pll_ok = 1'b0; // R8
    end

    if (i_wr_valid) begin
      r_next.wr_valid = r_reg.main_rst_b; // R3 R4
      r_next.wr_drop  = !r_reg.main_rst_b; // R3
      if (r_reg.main_rst_b) begin
        r_next.wr_addr = i_wr_addr; // R4
        r_next.wr_data = i_wr_data; // R4
      end
    end
    // reads answer in every state; held registers read their defaults
    if (i_rd_valid) begin
      r_next.rd_valid = 1'b1; // R11
      r_next.rd_addr  = i_rd_addr; // R11
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r_reg <= '{st: CPG_ST_UNDEF, cnt: '0, main_rst_b: 1'b0,
                 pll_ok: 1'b0, mode: CPG_MODE_I2C, wr_valid: 1'b0,
                 wr_drop: 1'b0, wr_addr: '0, wr_data: '0,
                 rd_valid: 1'b0, rd_addr: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign o_main_rst_b              = r_reg.main_rst_b;
  assign o_pll_rst_b               = r_reg.pll_ok; // R8 R13
  assign o_pll_enable              = r_reg.pll_ok; // R10
  assign o_xtal_enable             = r_reg.pll_ok; // R10
  assign o_clock_output_pin_enable = r_reg.pll_ok; // R10
  assign o_fully_operational       = r_reg.main_rst_b & r_reg.pll_ok; // R9
  assign o_ctrl_mode               = r_reg.mode;
  assign o_wr_valid                = r_reg.wr_valid;
  assign o_wr_addr                 = r_reg.wr_addr;
  assign o_wr_data                 = r_reg.wr_data;
  assign o_wr_dropped              = r_reg.wr_drop;
  assign o_rd_valid                = r_reg.rd_valid;
  assign o_rd_addr                 = r_reg.rd_addr;

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  a_release_needs_on: // R1
    assert property ($rose(r_reg.main_rst_b) |->
                     $past(s_an_on) && $past(s_core_on))
    else $error("main reset released without supplies on");
  a_held_above_det: // R2
    assert property (s_det && (r_reg.st == CPG_ST_UNDEF ||
                     r_reg.st == CPG_ST_HOLD) |=> !r_reg.main_rst_b)
    else $error("reset not held above detection level");
  a_write_dropped: // R3
    assert property (i_wr_valid && !r_reg.main_rst_b |=>
                     !r_reg.wr_valid && r_reg.wr_drop)
    else $error("write passed during reset");
  a_write_passed: // R4
    assert property (i_wr_valid && r_reg.main_rst_b |=>
                     r_reg.wr_valid && r_reg.wr_addr == $past(i_wr_addr))
    else $error("write lost after release");
  a_min_period: // R5
    assert property ($rose(r_reg.main_rst_b) |->
                     $past(r_reg.cnt) == POR_CYCLES - 1'b1)
    else $error("reset period too short");
  a_powerdown_reset: // R6
    assert property (r_reg.main_rst_b && (!s_an_off || !s_core_off) |=>
                     !r_reg.main_rst_b)
    else $error("reset not reasserted on power down");
  a_brownout_ride: // R7
    assert property (r_reg.main_rst_b && s_det && s_an_off && s_core_off
                     |=> r_reg.main_rst_b)
    else $error("reset entered during brown-out");
  a_pll_held: // R8
    assert property (!r_reg.pll_ok && !s_pll_on |=> !o_pll_rst_b)
    else $error("pll reset released below start-up");
  a_full_op: // R9
    assert property (o_fully_operational |-> r_reg.pll_ok &&
                     r_reg.st == CPG_ST_RUN)
    else $error("operational flag without all supplies");
  a_pll_indep: // R13
    assert property (r_reg.st == CPG_ST_COUNT && !r_reg.pll_ok && s_det &&
                     s_an_on && s_core_on &&
                     r_reg.cnt != POR_CYCLES - 1'b1 |=>
                     r_reg.cnt == $past(r_reg.cnt) + 1'b1)
    else $error("low pll supply stalled main reset");

endmodule
`default_nettype wire

/* File: cpg_supply_model.sv */
// supply monitor model: turns supply levels in millivolts into
// the comparator bits; assumes levels change only after a clock edge
`timescale 1ns/100ps
`default_nettype none
module cpg_supply_model
  import cpg_pkg::*;
(
  input  wire logic [12:0] i_an_mv,
  input  wire logic [12:0] i_core_mv,
  input  wire logic [12:0] i_pll_mv,
  output logic      [6:0]  o_mon
);
  // ****************************************************
  // comparators, one bit per threshold
  // ****************************************************
  // ideal comparators: no hysteresis beyond the documented split
  always_comb begin
    o_mon                = CPG_MON_RESET;
    o_mon[CPG_AN_DETECT] = i_an_mv > 13'h1f4;
    o_mon[CPG_AN_ON]     = i_an_mv > 13'h44c;
    o_mon[CPG_AN_OFF]    = i_an_mv > 13'h44c;
    o_mon[CPG_CORE_ON]   = i_core_mv > 13'h384;
    o_mon[CPG_CORE_OFF]  = i_core_mv > 13'h28a;
    o_mon[CPG_PLL_ON]    = i_pll_mv > 13'h44c;
    o_mon[CPG_PLL_OFF]   = i_pll_mv > 13'h44c;
  end
endmodule
`default_nettype wire

/* File: cpg_reset_gate_tb_top.sv */
// self-checking bench for the power-on reset gate
// assumes the supply model feeds the monitor bits
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  fail_count++; $display("BAD %0t got %h exp %h", $time, a, e); end end
module cpg_reset_gate_tb_top;
  import cpg_pkg::*;
  // short reset period keeps the run brief
  localparam logic [CPG_CNT_W-1:0] POR     = 12'h008;
  localparam logic [12:0]          MV_FULL = 13'h708;
  localparam logic [12:0]          MV_SAG  = 13'h320;
  localparam logic [12:0]          MV_LOW  = 13'h258;
  // pin to synced level: four edges
  localparam int                   SYNC_LAT = 4;
  logic        i_clk_sys, i_rst_b, i_wr_valid, i_rd_valid;
  logic [15:0] i_wr_addr, i_wr_data, i_rd_addr, o_wr_addr, o_wr_data;
  logic [15:0] o_rd_addr;
  logic [6:0]  mon;
  logic [1:0]  i_ctrl_mode, o_ctrl_mode;
  logic [12:0] an_mv, core_mv, pll_mv;
  logic        o_main_rst_b, o_pll_rst_b, o_pll_enable, o_xtal_enable;
  logic        o_clock_output_pin_enable, o_fully_operational;
  logic        o_wr_valid, o_wr_dropped, o_rd_valid;
  logic [31:0] r;
  int          fail_count, total_checks, n, seed;

  cpg_supply_model model (.i_an_mv(an_mv), .i_core_mv(core_mv),
    .i_pll_mv(pll_mv), .o_mon(mon));
  cpg_reset_gate #(.POR_CYCLES(POR)) dut (.i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b), .i_supply_mon(mon), .i_ctrl_mode(i_ctrl_mode),
    .i_wr_valid(i_wr_valid), .i_wr_addr(i_wr_addr),
    .i_wr_data(i_wr_data), .i_rd_valid(i_rd_valid),
    .i_rd_addr(i_rd_addr), .o_main_rst_b(o_main_rst_b),
    .o_pll_rst_b(o_pll_rst_b), .o_pll_enable(o_pll_enable),
    .o_xtal_enable(o_xtal_enable),
    .o_clock_output_pin_enable(o_clock_output_pin_enable),
    .o_fully_operational(o_fully_operational),
    .o_ctrl_mode(o_ctrl_mode), .o_wr_valid(o_wr_valid),
    .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
    .o_wr_dropped(o_wr_dropped), .o_rd_valid(o_rd_valid),
    .o_rd_addr(o_rd_addr));

  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end

  // ****************************************************
  // tasks
  // ****************************************************
  task automatic cyc();
    @(posedge i_clk_sys);
    #1;
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // request held one edge; left high so calls can run back to back
  task automatic xfer(input logic w, input logic [15:0] a, d);
    logic ok;
    ok = o_main_rst_b;
    i_wr_valid = w;
    i_rd_valid = !w;
    i_wr_addr = a;
    i_wr_data = d;
    i_rd_addr = a;
    cyc();
    if (w) begin
      `CHK(o_wr_valid, ok)
      `CHK(o_wr_dropped, !ok)
      if (ok) `CHK({o_wr_addr, o_wr_data}, {a, d})
    end else `CHK({o_rd_valid, o_rd_addr}, {1'b1, a})
  endtask

  task automatic idle();
    i_wr_valid = 1'b0;
    i_rd_valid = 1'b0;
    cyc();
  endtask

  // pll picks which reset is watched
  task automatic waitfor(input logic pll, input logic v, output int k);
    k = 0;
    while ((pll ? o_pll_rst_b : o_main_rst_b) !== v && k < 200) begin
      cyc();
      k++;
    end
    if (k >= 200) begin
      fail_count++;
      $display("BAD %0t wait ran out", $time);
      close_out();
    end
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    seed = 22;
    i_rst_b = 1'b0;
    i_wr_valid = 1'b0;
    i_rd_valid = 1'b0;
    i_wr_addr = 16'h0000;
    i_wr_data = 16'h0000;
    i_rd_addr = 16'h0000;
    i_ctrl_mode = 2'h0;
    an_mv = 13'h000;
    core_mv = 13'h000;
    pll_mv = 13'h000;
    repeat (2) @(posedge i_clk_sys);
    #1 i_rst_b = 1'b1;
    an_mv = MV_SAG;
    core_mv = MV_FULL;
    pll_mv = MV_FULL;
    repeat (6) cyc();
    for (int m = 0; m < 4; m++) begin
      i_ctrl_mode = 2'(m);
      repeat (SYNC_LAT + 1) cyc();
      `CHK(o_ctrl_mode, (m == 3) ? 2'h0 : 2'(m))
      `CHK({o_main_rst_b, o_fully_operational}, 2'h0)
    end
    xfer(1'b1, 16'hffff, 16'ha5a5);
    xfer(1'b0, 16'h0000, 16'h0000);
    idle();
    an_mv = MV_FULL;
    waitfor(1'b0, 1'b1, n);
    `CHK(n, POR + SYNC_LAT + 1)
    `CHK(o_fully_operational, 1'b1)
    for (int k = 0; k < 40; k++) begin
      r = $random(seed);
      xfer(r[0], r[31:16], r[15:0]);
    end
    idle();
    core_mv = MV_SAG;
    for (int k = 0; k < 30; k++) begin
      cyc();
      `CHK(o_main_rst_b, 1'b1)
    end
    core_mv = MV_FULL;
    pll_mv = 13'h000;
    waitfor(1'b1, 1'b0, n);
    `CHK(n, SYNC_LAT + 1)
    `CHK({o_main_rst_b, o_pll_enable, o_xtal_enable}, 3'h4)
    `CHK({o_clock_output_pin_enable, o_fully_operational}, 2'h0)
    xfer(1'b1, 16'h0001, 16'h1234);
    idle();
    pll_mv = MV_FULL;
    waitfor(1'b1, 1'b1, n);
    `CHK(o_fully_operational, 1'b1)
    // power-off of each main supply in turn, then full restart
    for (int s = 0; s < 2; s++) begin
      if (s == 0) an_mv = MV_SAG;
      else core_mv = MV_LOW;
      waitfor(1'b0, 1'b0, n);
      `CHK(n, SYNC_LAT + 1)
      xfer(1'b1, 16'h0002, 16'h5678);
      idle();
      an_mv = MV_FULL;
      core_mv = MV_FULL;
      // second restart runs with the pll supply off
      if (s == 1) pll_mv = 13'h000;
      waitfor(1'b0, 1'b1, n);
      `CHK(n, POR + SYNC_LAT + 1)
      `CHK({o_fully_operational, o_pll_rst_b}, {2{s == 0}})
    end
    close_out();
  end
endmodule
`default_nettype wire
